// file: tcc_pkg.sv
package tcc_pkg;
  // register byte addresses (chosen map, one aligned word each)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_CMP2 = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;
  localparam logic [7:0] ADDR_PRESC = 8'h18;
  // control register fields and reset values
  localparam int CTRL_TFF_BIT = 7;
  localparam int CTRL_OPT_BIT = 6;
  localparam int CTRL_START_LSB = 4;
  localparam int CTRL_CLK_LSB = 2;
  localparam int CTRL_MODE_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] CMP_RESET = 16'hffff;
  // prescale taps (log2 of divide) for clock-select codes 00, 01, 10
  localparam int TAP0 = 11;
  localparam int TAP1 = 7;
  localparam int TAP2 = 3;
  localparam int PRESC_W = 13;
  // status bits
  localparam int ST_MATCH = 0;
  localparam int ST_STOPPED = 1;
  localparam int ST_CAPTURE = 2;
  // start-control codes and the external clock-select code
  localparam logic [1:0] START_STOP = 2'h0;
  localparam logic [1:0] START_CMD = 2'h1;
  localparam logic [1:0] START_RISE = 2'h2;
  localparam logic [1:0] START_FALL = 2'h3;
  localparam logic [1:0] CLK_EXT = 2'h3;
  typedef enum logic [1:0] {
    TCC_MODE_TIMER, TCC_MODE_WINDOW, TCC_MODE_PULSE, TCC_MODE_PPG
  } tcc_mode_t;
  typedef enum logic [1:0] {TCC_IDLE, TCC_RUN, TCC_HALT} tcc_state_t;
endpackage

// file: tcc_dbuf.sv
`timescale 1ns/10ps
`default_nettype none
// byte-wise staged 16-bit register, activated on a source-clock tick
module tcc_dbuf #(
  parameter logic [15:0] RESET_VAL = 16'hffff
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [7:0] wdata_lo,
  input wire logic [7:0] wdata_hi,
  input wire logic tick,
  output logic [15:0] active
);
  typedef struct packed {
    logic [15:0] stage;
    logic pend;
    logic [15:0] act;
  } tcc_dbuf_st_t;
  tcc_dbuf_st_t s_q, s_d;

  // staged value only goes active once the upper byte arrives
  always_comb begin
    s_d = s_q;
    if (wr_lo) begin
      s_d.stage[7:0] = wdata_lo;
    end
    if (s_q.pend && tick) begin
      s_d.act = s_q.stage;
      s_d.pend = 1'b0;
    end
    if (wr_hi) begin
      s_d.stage[15:8] = wdata_hi;
      s_d.pend = 1'b1; // a new upper write re-arms pend; the old stage still transfers on this tick
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{stage: RESET_VAL, pend: 1'b0, act: RESET_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign active = s_q.act;

  property p_lo_only_no_change;
    @(posedge ref_clk) disable iff (!rst_n)
    (!s_q.pend && !wr_hi) |=> $stable(active);
  endproperty
  a_lo_only_no_change: assert property (p_lo_only_no_change)
    else $error("active value moved without upper byte write");

  property p_hi_then_tick;
    @(posedge ref_clk) disable iff (!rst_n)
    (s_q.pend && tick && !wr_hi) |=> (active == $past(s_q.stage));
  endproperty
  a_hi_then_tick: assert property (p_hi_then_tick)
    else $error("staged value not taken at source tick");
endmodule
`default_nettype wire

// file: tcc_timer.sv
`timescale 1ns/10ps
`default_nettype none
module tcc_timer #(
  parameter int CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic counter_pin,
  input wire logic stop_req,
  input wire logic prescale_halve_select,
  output logic timer_out,
  output logic irq
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [tcc_pkg::PRESC_W-1:0] presc;
    logic pin_d;
    logic [CNT_W-1:0] cnt;
    tcc_pkg::tcc_state_t st;
    logic tff;
    logic [CNT_W-1:0] cap;
    logic cap_vld;
    logic [31:0] rdata;
  } tcc_st_t;
  tcc_st_t s_q, s_d;

  logic wr_en, rd_en, mapped;
  logic [1:0] start_f, clk_f;
  tcc_pkg::tcc_mode_t mode_f;
  logic opt_f, tick, rise, fall, trig, anti, src_tick, match, pin_lvl;
  logic [15:0] period_act, cmp2_act;
  logic wr_per_lo, wr_per_hi, wr_cmp_lo, wr_cmp_hi;
  logic [2:0] ev;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr <= tcc_pkg::ADDR_PRESC) && (paddr[1:0] == 2'b00);
  assign pslverr = psel && penable && !mapped;
  assign prdata = s_q.rdata;

  // control field decode
  assign start_f = s_q.ctrl[tcc_pkg::CTRL_START_LSB +: 2];
  assign clk_f = s_q.ctrl[tcc_pkg::CTRL_CLK_LSB +: 2];
  assign mode_f = tcc_pkg::tcc_mode_t'(s_q.ctrl[tcc_pkg::CTRL_MODE_LSB +: 2]);
  assign opt_f = s_q.ctrl[tcc_pkg::CTRL_OPT_BIT];

  // pin edges; pin is taken as synchronous
  assign rise = counter_pin && !s_q.pin_d;
  assign fall = !counter_pin && s_q.pin_d;
  assign trig = (start_f == tcc_pkg::START_RISE) ? rise : fall;
  assign anti = (start_f == tcc_pkg::START_RISE) ? fall : rise;
  assign pin_lvl = (start_f == tcc_pkg::START_RISE) ? counter_pin : !counter_pin;

  // prescale tap tick; halve select doubles the divide
  always_comb begin
    logic [3:0] tap;
    tap = 4'h0;
    case (clk_f)
      2'h0: tap = 4'(tcc_pkg::TAP0);
      2'h1: tap = 4'(tcc_pkg::TAP1);
      default: tap = 4'(tcc_pkg::TAP2);
    endcase
    if (prescale_halve_select) begin
      tap = tap + 4'h1;
    end
    tick = (s_q.presc[tap-4'h1 -: 1] == 1'b1) &&
           ((s_q.presc & ((13'h1 << tap) - 13'h1)) == ((13'h1 << tap) - 13'h1));
  end

  // external clock counts selected pin edge; window gates the tick
  always_comb begin
    if (clk_f == tcc_pkg::CLK_EXT) begin
      src_tick = trig;
    end else if (mode_f == tcc_pkg::TCC_MODE_WINDOW) begin
      src_tick = tick && pin_lvl;
    end else begin
      src_tick = tick;
    end
  end

  assign wr_per_lo = wr_en && paddr == tcc_pkg::ADDR_PERIOD && pstrb[0];
  assign wr_per_hi = wr_en && paddr == tcc_pkg::ADDR_PERIOD && pstrb[1];
  // second compare is writable only in pulse-generator mode
  assign wr_cmp_lo = wr_en && paddr == tcc_pkg::ADDR_CMP2 && pstrb[0] &&
                     mode_f == tcc_pkg::TCC_MODE_PPG;
  assign wr_cmp_hi = wr_en && paddr == tcc_pkg::ADDR_CMP2 && pstrb[1] &&
                     mode_f == tcc_pkg::TCC_MODE_PPG;

  tcc_dbuf #(.RESET_VAL(tcc_pkg::CMP_RESET)) u_period (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_lo(wr_per_lo),
    .wr_hi(wr_per_hi),
    .wdata_lo(pwdata[7:0]),
    .wdata_hi(pwdata[15:8]),
    .tick(src_tick),
    .active(period_act)
  );
  tcc_dbuf #(.RESET_VAL(tcc_pkg::CMP_RESET)) u_cmp2 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_lo(wr_cmp_lo),
    .wr_hi(wr_cmp_hi),
    .wdata_lo(pwdata[7:0]),
    .wdata_hi(pwdata[15:8]),
    .tick(src_tick),
    .active(cmp2_act)
  );

  assign match = (s_q.cnt == CNT_W'(period_act));

  always_comb begin
    s_d = s_q;
    ev = 3'h0;
    s_d.presc = s_q.presc + 13'h1;
    s_d.pin_d = counter_pin;
    // counter sequencing per mode
    case (s_q.st)
      tcc_pkg::TCC_IDLE: begin
        if (start_f == tcc_pkg::START_CMD) begin
          s_d.st = tcc_pkg::TCC_RUN;
        end else if (start_f != tcc_pkg::START_STOP) begin
          // edge modes wait for trigger; event and window run at once
          if (clk_f == tcc_pkg::CLK_EXT || mode_f == tcc_pkg::TCC_MODE_WINDOW || trig) begin
            s_d.st = tcc_pkg::TCC_RUN;
          end
        end
      end
      tcc_pkg::TCC_RUN: begin
        if (src_tick) begin
          if (match) begin
            s_d.cnt = '0;
            ev[tcc_pkg::ST_MATCH] = 1'b1;
            if (mode_f == tcc_pkg::TCC_MODE_PPG) begin
              s_d.tff = !s_q.tff;
            end
            // trigger timer halts after match, free modes go on
            if (start_f != tcc_pkg::START_CMD && clk_f != tcc_pkg::CLK_EXT &&
                mode_f != tcc_pkg::TCC_MODE_WINDOW) begin
              s_d.st = opt_f && mode_f == tcc_pkg::TCC_MODE_PPG ? tcc_pkg::TCC_HALT
                       : tcc_pkg::TCC_IDLE;
            end
          end else begin
            s_d.cnt = s_q.cnt + CNT_W'(1);
            if (mode_f == tcc_pkg::TCC_MODE_PPG && s_q.cnt == CNT_W'(cmp2_act)) begin
              s_d.tff = !s_q.tff;
            end
          end
          // auto-capture on each source tick in timer and window modes
          if (opt_f && mode_f != tcc_pkg::TCC_MODE_PULSE && mode_f != tcc_pkg::TCC_MODE_PPG) begin
            s_d.cap = s_q.cnt;
            s_d.cap_vld = 1'b1;
            ev[tcc_pkg::ST_CAPTURE] = 1'b1;
          end
        end
        // pulse mode: opposite edge ends the measurement and captures
        if (mode_f == tcc_pkg::TCC_MODE_PULSE && anti) begin
          s_d.cap = s_q.cnt;
          s_d.cap_vld = 1'b1;
          ev[tcc_pkg::ST_CAPTURE] = 1'b1;
          s_d.cnt = '0;
          s_d.st = tcc_pkg::TCC_IDLE;
        end
      end
      tcc_pkg::TCC_HALT: begin
        s_d.cnt = '0; // one-shot done; wait for stop
      end
      default: s_d.st = tcc_pkg::TCC_IDLE;
    endcase
    if (!opt_f) begin
      s_d.cap_vld = 1'b0;
    end
    // register writes
    if (wr_en && paddr == tcc_pkg::ADDR_CTRL && pstrb[0]) begin
      s_d.ctrl = pwdata[7:0];
      // flip-flop initial level loads while stopped
      if (pwdata[tcc_pkg::CTRL_START_LSB +: 2] == tcc_pkg::START_STOP) begin
        s_d.tff = pwdata[tcc_pkg::CTRL_TFF_BIT];
      end
    end
    if (wr_en && paddr == tcc_pkg::ADDR_MASK && pstrb[0]) begin
      s_d.mask = pwdata[2:0];
    end
    if (wr_en && paddr == tcc_pkg::ADDR_STAT && pstrb[0]) begin
      s_d.stat = s_q.stat & ~pwdata[2:0];
    end
    // stop state entry forces a halt
    if (stop_req && start_f != tcc_pkg::START_STOP) begin
      s_d.ctrl[tcc_pkg::CTRL_START_LSB +: 2] = tcc_pkg::START_STOP;
      ev[tcc_pkg::ST_STOPPED] = 1'b1;
    end
    // stop and clear
    if (s_d.ctrl[tcc_pkg::CTRL_START_LSB +: 2] == tcc_pkg::START_STOP) begin
      s_d.cnt = '0;
      s_d.st = tcc_pkg::TCC_IDLE;
    end
    s_d.stat = s_d.stat | ev; // set wins over clear
    // read data captured at setup
    if (rd_en && !penable) begin
      case (paddr)
        tcc_pkg::ADDR_CTRL: s_d.rdata = {24'h0, s_q.ctrl};
        tcc_pkg::ADDR_PERIOD: s_d.rdata = {16'h0, period_act};
        tcc_pkg::ADDR_CMP2: s_d.rdata = (s_q.cap_vld) ? 32'(s_q.cap) : {16'h0, cmp2_act};
        tcc_pkg::ADDR_COUNT: s_d.rdata = 32'(s_q.cnt);
        tcc_pkg::ADDR_STAT: s_d.rdata = {29'h0, s_q.stat};
        tcc_pkg::ADDR_MASK: s_d.rdata = {29'h0, s_q.mask};
        default: s_d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{ctrl: tcc_pkg::CTRL_RESET, stat: 3'h0, mask: 3'h0, presc: '0, pin_d: 1'b0,
               cnt: '0, st: tcc_pkg::TCC_IDLE, tff: 1'b0, cap: '0, cap_vld: 1'b0,
               rdata: 32'h0};
    end else begin
      s_q <= s_d;
    end
  end

  assign timer_out = s_q.tff;
  assign irq = |(s_q.stat & s_q.mask);

  property p_stop_clears;
    @(posedge ref_clk) disable iff (!rst_n)
    (start_f == tcc_pkg::START_STOP) |=> (s_q.cnt == '0 || start_f != tcc_pkg::START_STOP);
  endproperty
  a_stop_clears: assert property (p_stop_clears)
    else $error("counter not cleared while stopped");

  property p_cmd_runs;
    @(posedge ref_clk) disable iff (!rst_n)
    (s_q.st == tcc_pkg::TCC_IDLE && start_f == tcc_pkg::START_CMD && !stop_req &&
     !(wr_en && paddr == tcc_pkg::ADDR_CTRL)) |=> (s_q.st == tcc_pkg::TCC_RUN);
  endproperty
  a_cmd_runs: assert property (p_cmd_runs)
    else $error("command start did not run");

  property p_rise_trigger;
    @(posedge ref_clk) disable iff (!rst_n)
    (s_q.st == tcc_pkg::TCC_IDLE && start_f == tcc_pkg::START_RISE && rise && !stop_req &&
     !wr_en) |=> (s_q.st == tcc_pkg::TCC_RUN);
  endproperty
  a_rise_trigger: assert property (p_rise_trigger)
    else $error("rising trigger missed");

  property p_neg_window;
    @(posedge ref_clk) disable iff (!rst_n)
    (s_q.st == tcc_pkg::TCC_RUN && mode_f == tcc_pkg::TCC_MODE_WINDOW &&
     start_f == tcc_pkg::START_FALL && clk_f != tcc_pkg::CLK_EXT && counter_pin) |-> !src_tick;
  endproperty
  a_neg_window: assert property (p_neg_window)
    else $error("negative window counted while pin high");

  property p_ext_clock;
    @(posedge ref_clk) disable iff (!rst_n)
    (clk_f == tcc_pkg::CLK_EXT && !trig) |-> !src_tick;
  endproperty
  a_ext_clock: assert property (p_ext_clock)
    else $error("external source ticked without pin edge");

  property p_stop_req;
    @(posedge ref_clk) disable iff (!rst_n)
    stop_req |=> (start_f == tcc_pkg::START_STOP) && (s_q.cnt == '0);
  endproperty
  a_stop_req: assert property (p_stop_req)
    else $error("stop state entry did not halt timer");

  property p_capture;
    @(posedge ref_clk) disable iff (!rst_n)
    (s_q.st == tcc_pkg::TCC_RUN && src_tick && opt_f && mode_f == tcc_pkg::TCC_MODE_TIMER &&
     !stop_req && !wr_en) |=> (s_q.cap == $past(s_q.cnt)) && s_q.cap_vld;
  endproperty
  a_capture: assert property (p_capture)
    else $error("auto-capture missed a source tick");

  property p_irq;
    @(posedge ref_clk) disable iff (!rst_n)
    (ev[tcc_pkg::ST_MATCH] && s_q.mask[tcc_pkg::ST_MATCH]) |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("match event did not raise interrupt");
endmodule
`default_nettype wire

// file: tcc_pulse_src.sv
`timescale 1ns/10ps
`default_nettype none
// external pulse source on the counter pin, each level held for at least 20 clocks
module tcc_pulse_src (
  input wire logic ref_clk,
  output var logic pin
);
  initial pin = 1'b0;
  // each level lasts 20 clocks, clear of any noise rejection window
  task automatic level(input logic v);
    @(posedge ref_clk);
    pin <= v;
    repeat (20) @(posedge ref_clk);
  endtask
  // one full pulse: one rising and one falling edge
  task automatic pulse();
    level(1'b1);
    level(1'b0);
  endtask
endmodule
`default_nettype wire

// file: test_tcc_timer.sv
`timescale 1ns/10ps
`default_nettype none
module test_tcc_timer;
  logic ref_clk, rst_n, psel, penable, pwrite, stop_req, prescale_halve_select;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, c;
  logic [3:0] pstrb;
  logic pready, pslverr, timer_out, irq, e, pin;
  int mismatches, compares;
  tcc_pulse_src tcc_pulse_src_i (.ref_clk(ref_clk), .pin(pin));
  tcc_timer tcc_timer_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .counter_pin(pin), .stop_req(stop_req),
    .prescale_halve_select(prescale_halve_select), .timer_out(timer_out), .irq(irq));
  // free-running clock, 100 ns period
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one apb transfer; request held until pready is seen high, at most 20 clocks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic er);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] x;
    logic y;
    apb(1'b1, a, d, s, x, y);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic y;
    apb(1'b0, a, 32'h0, 4'hf, d, y);
  endtask
  // reset values, field layout and every mode and clock code read back
  task automatic t_layout();
    rd(tcc_pkg::ADDR_CTRL, r);
    check(r, 32'h0);
    rd(tcc_pkg::ADDR_PERIOD, r);
    check(r[15:0], 16'hffff);
    for (int i = 0; i < 16; i++) begin
      wr(tcc_pkg::ADDR_CTRL, 32'h40 | i, 4'h1);
      rd(tcc_pkg::ADDR_CTRL, r);
      check(r[7:0], 8'h40 | i);
    end
    wr(tcc_pkg::ADDR_CTRL, 32'h0, 4'h1);
    apb(1'b0, 8'h1c, 32'h0, 4'hf, r, e);
    check(r, 32'h0);
    check(e, 1'b1);
  endtask
  // command start on each prescale tap, then stop clears the count
  task automatic t_prescale();
    int dv;
    for (int k = 0; k < 6; k++) begin
      prescale_halve_select <= k[0];
      dv = (k < 2) ? 8 : (k < 4) ? 128 : 2048;
      dv = dv << k[0];
      wr(tcc_pkg::ADDR_CTRL, 32'h08 - (k / 2) * 4, 4'h1);
      wr(tcc_pkg::ADDR_CTRL, 32'h18 - (k / 2) * 4, 4'h1);
      repeat (4 * dv) @(posedge ref_clk);
      rd(tcc_pkg::ADDR_COUNT, r);
      check(r[15:0] >= 3 && r[15:0] <= 5, 1'b1);
      wr(tcc_pkg::ADDR_CTRL, 32'h0, 4'h1);
      rd(tcc_pkg::ADDR_COUNT, r);
      check(r, 32'h0);
    end
    prescale_halve_select <= 1'b0;
  endtask
  // capture follows the running counter; count read first so a tick between reads is harmless
  task automatic t_capture();
    wr(tcc_pkg::ADDR_CTRL, 32'h48, 4'h1);
    wr(tcc_pkg::ADDR_CTRL, 32'h58, 4'h1);
    repeat (200) @(posedge ref_clk);
    rd(tcc_pkg::ADDR_COUNT, r);
    rd(tcc_pkg::ADDR_CMP2, c);
    check(r[15:0] - c[15:0] <= 1 && r[15:0] > 16, 1'b1);
    wr(tcc_pkg::ADDR_CTRL, 32'h0, 4'h1);
  endtask
  // negative-logic window: counts only while the pin is low
  task automatic t_window();
    wr(tcc_pkg::ADDR_CTRL, 32'h09, 4'h1);
    wr(tcc_pkg::ADDR_CTRL, 32'h39, 4'h1);
    tcc_pulse_src_i.level(1'b1);
    rd(tcc_pkg::ADDR_COUNT, r);
    tcc_pulse_src_i.level(1'b1);
    rd(tcc_pkg::ADDR_COUNT, c);
    check(c, r);
    tcc_pulse_src_i.level(1'b0);
    rd(tcc_pkg::ADDR_COUNT, c);
    check(c[15:0] > r[15:0], 1'b1);
    wr(tcc_pkg::ADDR_CTRL, 32'h0, 4'h1);
  endtask
  // rising and falling edge counting from the pin
  task automatic t_edges();
    wr(tcc_pkg::ADDR_CTRL, 32'h0c, 4'h1);
    wr(tcc_pkg::ADDR_CTRL, 32'h2c, 4'h1);
    tcc_pulse_src_i.level(1'b1);
    tcc_pulse_src_i.level(1'b0);
    rd(tcc_pkg::ADDR_COUNT, r);
    check(r, 32'h1);
    wr(tcc_pkg::ADDR_CTRL, 32'h0c, 4'h1);
    wr(tcc_pkg::ADDR_CTRL, 32'h3c, 4'h1);
    tcc_pulse_src_i.level(1'b1);
    rd(tcc_pkg::ADDR_COUNT, r);
    check(r, 32'h0);
    tcc_pulse_src_i.level(1'b0);
    rd(tcc_pkg::ADDR_COUNT, r);
    check(r, 32'h1);
    wr(tcc_pkg::ADDR_CTRL, 32'h0, 4'h1);
  endtask
  // staged period bytes, match status, mask and write-one clear
  task automatic t_compare();
    wr(tcc_pkg::ADDR_MASK, 32'h0, 4'hf);
    wr(tcc_pkg::ADDR_CTRL, 32'h0c, 4'h1);
    wr(tcc_pkg::ADDR_CTRL, 32'h2c, 4'h1);
    wr(tcc_pkg::ADDR_PERIOD, 32'h10, 4'h3);
    repeat (2) tcc_pulse_src_i.pulse();
    wr(tcc_pkg::ADDR_PERIOD, 32'h03, 4'h1);
    repeat (2) tcc_pulse_src_i.pulse();
    rd(tcc_pkg::ADDR_STAT, r);
    check(r[0], 1'b0);
    wr(tcc_pkg::ADDR_PERIOD, 32'h07, 4'h3);
    repeat (2) tcc_pulse_src_i.pulse();
    rd(tcc_pkg::ADDR_STAT, r);
    check(r[0], 1'b0);
    check(irq, 1'b0);
    // match fires on the tick after the count reaches the period
    repeat (2) tcc_pulse_src_i.pulse();
    rd(tcc_pkg::ADDR_STAT, r);
    check(r[0], 1'b1);
    wr(tcc_pkg::ADDR_MASK, 32'h1, 4'hf);
    @(negedge ref_clk);
    check(irq, 1'b1);
    wr(tcc_pkg::ADDR_STAT, 32'h1, 4'hf);
    @(negedge ref_clk);
    check(irq, 1'b0);
    wr(tcc_pkg::ADDR_CTRL, 32'h0, 4'h1);
  endtask
  // stop entry forces the start field back to stopped
  task automatic t_stop();
    wr(tcc_pkg::ADDR_MASK, 32'h2, 4'hf);
    wr(tcc_pkg::ADDR_CTRL, 32'h18, 4'h1);
    @(posedge ref_clk);
    stop_req <= 1'b1;
    repeat (3) @(posedge ref_clk);
    stop_req <= 1'b0;
    rd(tcc_pkg::ADDR_CTRL, r);
    check(r[5:4], 2'h0);
    check(r[3:0], 4'h8);
    check(irq, 1'b1);
    wr(tcc_pkg::ADDR_STAT, 32'h2, 4'hf);
    @(negedge ref_clk);
    check(irq, 1'b0);
  endtask
  // pulse generator: second compare writable only there, flip-flop preset while stopped
  task automatic t_ppg();
    wr(tcc_pkg::ADDR_CTRL, 32'h0b, 4'h1);
    wr(tcc_pkg::ADDR_CMP2, 32'h0005, 4'h3);
    repeat (20) @(posedge ref_clk);
    rd(tcc_pkg::ADDR_CMP2, r);
    check(r, 32'h5);
    wr(tcc_pkg::ADDR_CTRL, 32'h8b, 4'h1);
    @(negedge ref_clk);
    check(timer_out, 1'b1);
    wr(tcc_pkg::ADDR_CTRL, 32'h00, 4'h1);
    @(negedge ref_clk);
    check(timer_out, 1'b0);
    wr(tcc_pkg::ADDR_CMP2, 32'h0055, 4'h3);
    repeat (20) @(posedge ref_clk);
    rd(tcc_pkg::ADDR_CMP2, r);
    check(r, 32'h5);
  endtask
  // main sequence; inputs start at time zero
  initial begin
    mismatches = 0;
    compares = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    stop_req = 1'b0;
    prescale_halve_select = 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_layout();
    t_prescale();
    t_capture();
    t_window();
    t_edges();
    t_compare();
    t_stop();
    t_ppg();
    results();
  end
  // watchdog sized well above the roughly 30k cycles of the run
  initial begin
    #8000000;
    mismatches++;
    results();
  end
endmodule
`default_nettype wire
